// ---- hdl/pulse_accum_pkg.sv ----
// constants and register map of the pulse accumulator
// Operation
// R01 - enable bit 6 turns the whole accumulator on or off
// R02 - accumulator enable works regardless of the timer master enable
// R03 - mode bit 5 picks event counting or gated time accumulation when enabled
// R04 - event mode counts falling edges when edge bit 4 is 0, rising when 1
// R05 - gated mode counts div-64 ticks during active level; trailing edge sets input flag
// R06 - overflow flag set when the counter wraps from all ones to zero
// R07 - overflow flag requests interrupt only while its enable bit is set
// R08 - input flag requests interrupt only while its enable bit is set
// R09 - div-64 tick comes from timer prescaler; no tick while timer is off
// R10 - source holds each pulse longer than two bus clocks
// R11 - software frees the shared pin from channel 7 output logic first
// R12 - counter holds edges or ticks accumulated since last reset
// R13 - flags stay set until software writes one; clearing drops the request
package pulse_accum_pkg;
  // ***********************************
  // register byte addresses
  // ***********************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_COUNTER = 8'h08;
  localparam logic [7:0] ADDR_TIMER = 8'h0C;
  // ***********************************
  // control and flag field positions
  // ***********************************
  localparam int CTL_EN_BIT = 6;
  localparam int CTL_MODE_BIT = 5;
  localparam int CTL_EDGE_BIT = 4;
  localparam int CTL_OVI_BIT = 1;
  localparam int CTL_PAI_BIT = 0;
  localparam logic [7:0] CTL_WMASK = 8'h73;
  localparam int FLG_OVF_BIT = 1;
  localparam int FLG_IF_BIT = 0;
  // ***********************************
  // reset values and counts
  // ***********************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam int PRESCALE_DIV = 64;
  localparam logic [5:0] PRESCALE_LAST = 6'(PRESCALE_DIV - 1);
endpackage : pulse_accum_pkg

// ---- hdl/pin_sync.sv ----
// three-stage synchroniser with agreement filter for the accumulator pin
`timescale 1ns/10ps
module pin_sync (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic level;
  logic next_level;

  always_comb begin
    next_stage = {stage[1:0], pin_i};
    // only stages two and three are compared; stage one feeds stage two alone
    next_level = (stage[1] == stage[2]) ? stage[1] : level;
    if (srst_i) begin
      next_stage = 3'h0;
      next_level = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    stage <= next_stage;
    level <= next_level;
  end

  assign level_o = level;
endmodule : pin_sync

// ---- hdl/prescale_tick.sv ----
// timer prescaler producing the bus-clock-divided-by-64 tick
`timescale 1ns/10ps
module prescale_tick (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [5:0] count;
  logic [5:0] next_count;
  logic tick;
  logic next_tick;

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (run_i) begin
      next_count = 6'(count + 6'h01);
      next_tick = (count == pulse_accum_pkg::PRESCALE_LAST);
    end
    if (srst_i) begin
      next_count = 6'h00;
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    count <= next_count;
    tick <= next_tick;
  end

  assign tick_o = tick;
endmodule : prescale_tick

// ---- hdl/pulse_accum.sv ----
// 16-bit pulse accumulator with apb register access
`timescale 1ns/10ps
module pulse_accum (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shared_channel_seven_pin_i,
  output logic irq_o
);
  // ***********************************
  // register state
  // ***********************************
  logic [7:0] accum_control;
  logic [7:0] next_accum_control;
  logic [15:0] accum_counter;
  logic [15:0] next_accum_counter;
  logic accum_overflow_flag;
  logic next_accum_overflow_flag;
  logic accum_input_flag;
  logic next_accum_input_flag;
  logic timer_master_enable;
  logic next_timer_master_enable;
  logic pin_prev;
  logic next_pin_prev;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ready;
  logic next_ready;
  logic slverr;
  logic next_slverr;
  logic irq;
  logic next_irq;

  logic pin_level;
  logic tick;
  logic enabled;
  logic gated;
  logic edge_sel;
  logic rise;
  logic fall;
  logic active_edge;
  logic active_level;
  logic trailing_edge;
  logic inc;
  logic wr;
  logic rd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(shared_channel_seven_pin_i),
    .level_o(pin_level)
  );

  prescale_tick u_presc (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .run_i(timer_master_enable), // R09
    .tick_o(tick)
  );

  // ***********************************
  // counting decisions
  // ***********************************
  always_comb begin
    enabled = accum_control[pulse_accum_pkg::CTL_EN_BIT]; // R01 R02
    gated = accum_control[pulse_accum_pkg::CTL_MODE_BIT]; // R03
    edge_sel = accum_control[pulse_accum_pkg::CTL_EDGE_BIT];
    rise = pin_level & ~pin_prev;
    fall = ~pin_level & pin_prev;
    active_edge = edge_sel ? rise : fall; // R04
    active_level = edge_sel ? ~pin_level : pin_level; // R05
    // trailing edge of the active level is the opposite of the level's start
    trailing_edge = edge_sel ? rise : fall; // R05
    inc = enabled & (gated ? (active_level & tick) : active_edge); // R12
    wr = psel & penable & pwrite & ~ready;
    rd = psel & penable & ~pwrite & ~ready;
  end

  // ***********************************
  // registers and flags
  // ***********************************
  always_comb begin
    next_accum_control = accum_control;
    next_accum_counter = accum_counter;
    next_accum_overflow_flag = accum_overflow_flag;
    next_accum_input_flag = accum_input_flag;
    next_timer_master_enable = timer_master_enable;
    next_pin_prev = pin_level;
    if (wr && hit(paddr, pulse_accum_pkg::ADDR_CONTROL)) begin
      next_accum_control = pwdata[7:0] & pulse_accum_pkg::CTL_WMASK;
    end
    if (wr && hit(paddr, pulse_accum_pkg::ADDR_TIMER)) begin
      next_timer_master_enable = pwdata[0];
    end
    if (wr && hit(paddr, pulse_accum_pkg::ADDR_FLAGS)) begin
      // write one to clear; a same-cycle event below wins
      if (pwdata[pulse_accum_pkg::FLG_OVF_BIT]) begin
        next_accum_overflow_flag = 1'b0; // R13
      end
      if (pwdata[pulse_accum_pkg::FLG_IF_BIT]) begin
        next_accum_input_flag = 1'b0; // R13
      end
    end
    if (wr && hit(paddr, pulse_accum_pkg::ADDR_COUNTER)) begin
      next_accum_counter = pwdata[15:0];
    end else if (inc) begin
      next_accum_counter = 16'(accum_counter + 16'h0001); // R12
      if (accum_counter == pulse_accum_pkg::COUNTER_MAX) begin
        next_accum_overflow_flag = 1'b1; // R06
      end
    end
    if (enabled && gated && trailing_edge) begin
      next_accum_input_flag = 1'b1; // R05
    end
    if (srst_i) begin
      next_accum_control = pulse_accum_pkg::CONTROL_RESET;
      next_accum_counter = pulse_accum_pkg::COUNTER_RESET;
      next_accum_overflow_flag = 1'b0;
      next_accum_input_flag = 1'b0;
      next_timer_master_enable = 1'b0;
      next_pin_prev = 1'b0;
    end
  end

  // ***********************************
  // apb answer and interrupt
  // ***********************************
  always_comb begin
    next_ready = psel & penable & ~ready;
    next_slverr = 1'b0;
    next_rdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        pulse_accum_pkg::ADDR_CONTROL: begin
          next_rdata = {24'h000000, accum_control};
        end
        pulse_accum_pkg::ADDR_FLAGS: begin
          next_rdata = {30'h0000_0000, accum_overflow_flag, accum_input_flag};
        end
        pulse_accum_pkg::ADDR_COUNTER: begin
          next_rdata = {16'h0000, accum_counter};
        end
        pulse_accum_pkg::ADDR_TIMER: begin
          next_rdata = {31'h0000_0000, timer_master_enable};
        end
        default: begin
          next_slverr = 1'b1;
        end
      endcase
    end
    if (wr && !(hit(paddr, pulse_accum_pkg::ADDR_CONTROL)
        || hit(paddr, pulse_accum_pkg::ADDR_FLAGS)
        || hit(paddr, pulse_accum_pkg::ADDR_COUNTER)
        || hit(paddr, pulse_accum_pkg::ADDR_TIMER))) begin
      next_slverr = 1'b1;
    end
    // irq follows the flags registered this edge, so a cleared flag drops it
    next_irq = (next_accum_overflow_flag & next_accum_control[pulse_accum_pkg::CTL_OVI_BIT]) // R07
      | (next_accum_input_flag & next_accum_control[pulse_accum_pkg::CTL_PAI_BIT]); // R08
    if (srst_i) begin
      next_ready = 1'b0;
      next_slverr = 1'b0;
      next_rdata = 32'h0000_0000;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    accum_control <= next_accum_control;
    accum_counter <= next_accum_counter;
    accum_overflow_flag <= next_accum_overflow_flag;
    accum_input_flag <= next_accum_input_flag;
    timer_master_enable <= next_timer_master_enable;
    pin_prev <= next_pin_prev;
    rdata <= next_rdata;
    ready <= next_ready;
    slverr <= next_slverr;
    irq <= next_irq;
  end

  assign prdata = rdata;
  assign pready = ready;
  assign pslverr = slverr;
  assign irq_o = irq;

  // ***********************************
  // assertions
  // ***********************************
  sequence s_wrap;
    inc && accum_counter == 16'hFFFF && !wr;
  endsequence

  // clears with no event in the same cycle; the set-wins case is left out on purpose
  sequence s_clear_input;
    wr && hit(paddr, pulse_accum_pkg::ADDR_FLAGS) && pwdata[pulse_accum_pkg::FLG_IF_BIT]
      && !(enabled && gated && trailing_edge);
  endsequence

  sequence s_clear_overflow;
    wr && hit(paddr, pulse_accum_pkg::ADDR_FLAGS) && pwdata[pulse_accum_pkg::FLG_OVF_BIT]
      && !(inc && accum_counter == 16'hFFFF);
  endsequence

  sequence s_clear_both;
    wr && hit(paddr, pulse_accum_pkg::ADDR_FLAGS) && pwdata[1:0] == 2'h3
      && !(enabled && gated && trailing_edge) && !(inc && accum_counter == 16'hFFFF);
  endsequence

  AST_DISABLED_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    !enabled && !wr |=> $stable(accum_counter))
    else $error("counter moved while disabled");

  AST_EVENT_NO_TIMER: assert property (@(posedge core_clk_i) disable iff (srst_i) // R02
    enabled && !gated && active_edge && !timer_master_enable && !wr
    && accum_counter != 16'hFFFF |=> accum_counter == $past(accum_counter) + 16'h0001)
    else $error("event edge not counted with timer off");

  AST_GATED_NO_EDGE: assert property (@(posedge core_clk_i) disable iff (srst_i) // R03
    enabled && gated && !tick && !wr |=> $stable(accum_counter))
    else $error("gated mode counted without tick");

  AST_FALL_COUNT: assert property (@(posedge core_clk_i) disable iff (srst_i) // R04
    enabled && !gated && !edge_sel && fall && !wr && accum_counter != 16'hFFFF
    |=> accum_counter == $past(accum_counter) + 16'h0001)
    else $error("falling edge not counted");

  AST_TRAIL_FLAG: assert property (@(posedge core_clk_i) disable iff (srst_i) // R05
    enabled && gated && trailing_edge |=> accum_input_flag)
    else $error("trailing edge did not set input flag");

  AST_WRAP_FLAG: assert property (@(posedge core_clk_i) disable iff (srst_i) // R06
    s_wrap |=> accum_overflow_flag && accum_counter == 16'h0000)
    else $error("wrap did not set overflow");

  AST_OVF_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i) // R07
    accum_overflow_flag && accum_control[1] |-> irq)
    else $error("overflow irq missing");

  AST_IF_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i) // R08
    irq |-> (accum_input_flag && accum_control[0]) || (accum_overflow_flag && accum_control[1]))
    else $error("irq without enabled flag");

  AST_NO_TICK: assert property (@(posedge core_clk_i) disable iff (srst_i) // R09
    !timer_master_enable ##1 !timer_master_enable |-> !tick)
    else $error("tick while timer off");

  AST_FLAG_STICKY: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
    accum_input_flag && !wr |=> accum_input_flag)
    else $error("input flag dropped without clear");

  AST_DISABLED_NO_OVF: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    !enabled && !accum_overflow_flag |=> !accum_overflow_flag)
    else $error("overflow set while disabled");

  AST_RISE_COUNT: assert property (@(posedge core_clk_i) disable iff (srst_i) // R04
    enabled && !gated && edge_sel && rise && !wr && accum_counter != 16'hFFFF
    |=> accum_counter == $past(accum_counter) + 16'h0001)
    else $error("rising edge not counted");

  AST_GATED_TICK: assert property (@(posedge core_clk_i) disable iff (srst_i) // R05
    enabled && gated && active_level && tick && !wr && accum_counter != 16'hFFFF
    |=> accum_counter == $past(accum_counter) + 16'h0001)
    else $error("gated tick not counted");

  AST_GATED_IDLE: assert property (@(posedge core_clk_i) disable iff (srst_i) // R05
    enabled && gated && !active_level && !wr |=> $stable(accum_counter))
    else $error("gated mode counted outside active level");

  AST_EVENT_NO_FLAG: assert property (@(posedge core_clk_i) disable iff (srst_i) // R05
    !accum_input_flag && !(enabled && gated) |=> !accum_input_flag)
    else $error("input flag set outside gated mode");

  AST_IN_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i) // R08
    accum_input_flag && accum_control[pulse_accum_pkg::CTL_PAI_BIT] |-> irq)
    else $error("input irq missing");

  // the prescaler wraps only every sixty-four edges, so two ticks never touch
  AST_TICK_SPACING: assert property (@(posedge core_clk_i) disable iff (srst_i) // R09
    tick |=> !tick)
    else $error("tick on two edges in a row");

  AST_CNT_LOAD: assert property (@(posedge core_clk_i) disable iff (srst_i) // R12
    wr && hit(paddr, pulse_accum_pkg::ADDR_COUNTER) |=> accum_counter == $past(pwdata[15:0]))
    else $error("counter write lost");

  AST_OVF_STICKY: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
    accum_overflow_flag && !wr |=> accum_overflow_flag)
    else $error("overflow flag dropped without clear");

  AST_CLR_INPUT: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
    s_clear_input |=> !accum_input_flag)
    else $error("input flag not cleared");

  AST_CLR_OVERFLOW: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
    s_clear_overflow |=> !accum_overflow_flag)
    else $error("overflow flag not cleared");

  AST_CLR_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
    s_clear_both |=> !irq)
    else $error("irq stayed up after both flags cleared");
endmodule : pulse_accum

// ---- sim/pulse_src.sv ----
// behavioural pulse and gate source on the shared pin
`timescale 1ns/10ps
module pulse_src (
  input wire logic core_clk_i,
  output logic pin_o
);
  initial pin_o = 1'b1;
  // *****
  // drive
  // *****
  // level change is itself an edge: set it before enabling the accumulator
  task automatic level(input logic lvl);
    @(posedge core_clk_i);
    pin_o <= lvl;
    repeat (8) @(posedge core_clk_i);
  endtask : level
  task automatic pulses(input int n, input int w);
    logic idle;
    int hw;
    idle = pin_o;
    hw = (w < 3) ? 3 : w;
    for (int i = 0; i < n; i++) begin
      pin_o <= ~idle;
      repeat (hw) @(posedge core_clk_i);
      pin_o <= idle;
      repeat (hw) @(posedge core_clk_i);
    end
    repeat (8) @(posedge core_clk_i);
  endtask : pulses
endmodule : pulse_src

// ---- sim/pulse_accum_tb.sv ----
// self-checking bench for the pulse accumulator
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((ex) !== (got)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module pulse_accum_tb;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  logic irq_o;
  logic [31:0] rd;
  logic er;
  logic [15:0] base;
  logic [7:0] v;
  int n;
  int err_total = 0;
  int n_tests = 0;
  initial forever #25 core_clk_i = ~core_clk_i;
  pulse_accum i_pulse_accum (.core_clk_i(core_clk_i), .srst_i(srst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shared_channel_seven_pin_i(pin), .irq_o(irq_o));
  // the source alone drives the pin: no channel 7 output logic sits on it
  pulse_src i_pulse_src (.core_clk_i(core_clk_i), .pin_o(pin));
  // *****
  // tasks
  // *****
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // waits an edge first so no strobe is assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    // no answer time is assumed: only the watchdog ends a wait that never answers
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h00000000);
    `CHK(nm, ex, rd)
  endtask : rc
  function automatic logic [31:0] ctl(input logic e, input logic [7:0] b);
    return 32'(b) | (32'(e) << pulse_accum_pkg::CTL_EDGE_BIT);
  endfunction : ctl
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    conclude();
  end
  // *****
  // tests
  // *****
  initial begin
    void'($urandom(32'h2FBAA2A3));
    repeat (6) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rc("ctl", pulse_accum_pkg::ADDR_CONTROL, 32'h00000000);
    rc("cnt", pulse_accum_pkg::ADDR_COUNTER, 32'h00000000);
    rc("flg", pulse_accum_pkg::ADDR_FLAGS, 32'h00000000);
    apb(1'b0, 8'h10, 32'h00000000);
    `CHK("slverr", 1'b1, er)
    // pin is steady and the timer off, so random modes cannot count
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, 32'(v));
      rc("ctlrw", pulse_accum_pkg::ADDR_CONTROL, 32'(v & pulse_accum_pkg::CTL_WMASK));
    end
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, 32'h00000000);
      i_pulse_src.level(e[0]);
      base = 16'($urandom % 16'hFF00);
      n = 1 + $urandom % 8;
      apb(1'b1, pulse_accum_pkg::ADDR_COUNTER, 32'(base));
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, ctl(e[0], 8'h40));
      i_pulse_src.pulses(n, 3 + $urandom % 4);
      rc("evcnt", pulse_accum_pkg::ADDR_COUNTER, 32'(16'(base + n)));
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, ctl(e[0], 8'h00));
      i_pulse_src.pulses(3, 4);
      rc("offcnt", pulse_accum_pkg::ADDR_COUNTER, 32'(16'(base + n)));
    end
    apb(1'b1, pulse_accum_pkg::ADDR_COUNTER, 32'h0000FFFE);
    apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, 32'h00000040);
    i_pulse_src.pulses(2, 3);
    rc("wrap", pulse_accum_pkg::ADDR_COUNTER, 32'h00000000);
    rc("ovf", pulse_accum_pkg::ADDR_FLAGS, 32'h00000002);
    `CHK("irqmask", 1'b0, irq_o)
    apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, 32'h00000042);
    @(posedge core_clk_i);
    `CHK("irqovf", 1'b1, irq_o)
    apb(1'b1, pulse_accum_pkg::ADDR_FLAGS, 32'h00000003);
    @(posedge core_clk_i);
    `CHK("irqclr", 1'b0, irq_o)
    rc("flgclr", pulse_accum_pkg::ADDR_FLAGS, 32'h00000000);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, 32'h00000000);
      i_pulse_src.level(e[0]);
      apb(1'b1, pulse_accum_pkg::ADDR_TIMER, 32'h00000000);
      apb(1'b1, pulse_accum_pkg::ADDR_COUNTER, 32'h00000000);
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, ctl(e[0], 8'h61));
      apb(1'b1, pulse_accum_pkg::ADDR_FLAGS, 32'h00000003);
      i_pulse_src.pulses(1, 320);
      rc("notick", pulse_accum_pkg::ADDR_COUNTER, 32'h00000000);
      rc("trail", pulse_accum_pkg::ADDR_FLAGS, 32'h00000001);
      `CHK("irqin", 1'b1, irq_o)
      apb(1'b1, pulse_accum_pkg::ADDR_FLAGS, 32'h00000001);
      apb(1'b1, pulse_accum_pkg::ADDR_TIMER, 32'h00000001);
      i_pulse_src.pulses(1, 320);
      apb(1'b0, pulse_accum_pkg::ADDR_COUNTER, 32'h00000000);
      // tick phase against the gate is free, yet a 320-cycle gate holds five ticks; the check allows one either side
      `CHK("gated", 1'b1, (rd[15:0] >= 16'h0004) && (rd[15:0] <= 16'h0006))
      apb(1'b1, pulse_accum_pkg::ADDR_CONTROL, ctl(e[0], 8'h60));
      @(posedge core_clk_i);
      `CHK("irqinoff", 1'b0, irq_o)
    end
    conclude();
  end
endmodule : pulse_accum_tb
